//--- aqs_cfg.svh
// Constants for the activity source qualifier: offsets, fields, reset values, timing.
`ifndef AQS_CFG_SVH
`define AQS_CFG_SVH

`define AQS_MASK_ADDR       16'hd872
`define AQS_CTRL_ADDR       16'hb072
`define AQS_MASK_RESET      16'h0000
`define AQS_WORD_W          16

`define AQS_MASK_PCS        15
`define AQS_MASK_POL        14
`define AQS_MASK_SEL_HI     13
`define AQS_MASK_SEL_LO     11
`define AQS_MASK_NMI        10
`define AQS_MASK_DISK       9
`define AQS_MASK_COP        8
`define AQS_MASK_ATTN_HI    7
`define AQS_MASK_ATTN_LO    6
`define AQS_MASK_RTC_REQ    5
`define AQS_MASK_PAR_REQ    4
`define AQS_MASK_TICK_REQ   3
`define AQS_MASK_RTC_SVC    2
`define AQS_MASK_PAR_SVC    1
`define AQS_MASK_TICK_SVC   0

`define AQS_CTRL_REQ_EN     15
`define AQS_CTRL_LATCH      12
`define AQS_CTRL_INACTIVITY_DETECTED      11
`define AQS_CTRL_AFTER      10
`define AQS_CTRL_BEFORE     9
`define AQS_CTRL_ENABLE     8
`define AQS_SETTING_RESET   8'h00

`define AQS_SEL_FIRST_OFF   3'h6
`define AQS_IRQ_TICK        0
`define AQS_IRQ_CASCADE     2
`define AQS_IRQ_GATED_A     3
`define AQS_IRQ_GATED_B     4
`define AQS_IRQ_PARALLEL    7
`define AQS_IRQ_RTC         8
`define AQS_ATTN_LINE_0     4'h5
`define AQS_ATTN_LINE_1     4'ha
`define AQS_ATTN_LINE_2     4'hb
`define AQS_ATTN_LINE_3     4'hf

`define AQS_COP_FIRST       16'h00f8
`define AQS_COP_LAST        16'h00ff

`define AQS_CLK_PERIOD_NS   4
`define AQS_FINE_STEP_NS    7800000
`define AQS_COARSE_STEP_S   64
`define AQS_NS_PER_S        1000000000
`define AQS_TIMER_W         17
`define AQS_PRESC_W         21
`define AQS_SRC_W           43

`endif

//--- aqs_pkg.sv
// Types shared by the activity source qualifier.
package aqs_pkg;
    typedef enum logic [1:0] {
        AQS_IDLE  = 2'b01,
        AQS_COUNT = 2'b10
    } aqs_state_t;
    typedef logic [15:0] aqs_word_t;
endpackage

//--- aqs_edge_pulse.sv
// Per-source rising edge detector producing one-cycle activity pulses.
`timescale 1ns/1ns
`default_nettype none
`include "aqs_cfg.svh"
module aqs_edge_pulse
    import aqs_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [`AQS_SRC_W-1:0] srcLevel,
    output logic      [`AQS_SRC_W-1:0] srcPulse
);
    logic [`AQS_SRC_W-1:0] prev_q;
    logic [`AQS_SRC_W-1:0] prev_d;

    always_comb begin
        prev_d = srcLevel;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // A level already standing at reset release is not an edge
            prev_q <= '1;
        end else begin
            prev_q <= prev_d;
        end
    end

    // A source held high counts once, not for every cycle it stays up
    assign srcPulse = srcLevel & ~prev_q; // [RULE_22]
endmodule
`default_nettype wire

//--- aqs_activity_qualifier.sv
// Activity source qualifier with inactivity timeout and its two I/O port registers.
//
// Notes on behaviour
// RULE_01: Enabled monitor counts, timeout raises local attention
// RULE_02: Unmasked activity restarts the count from zero
// RULE_03: Interrupts, power input, NMI, DMA, I/O count
// RULE_04: Cascade line 2 never counts as activity
// RULE_05: Lines 3,4 requests gated by controller mask
// RULE_06: Requests count only with request master enable
// RULE_07: Sixteen-bit mask register at port d872
// RULE_08: Mask bit 15 ignores chip-select range I/O
// RULE_09: Mask bit 14 picks power input polarity
// RULE_10: Mask bits 13-11 select watched power input
// RULE_11: Software clears latch enables of watched input
// RULE_12: Mask bit 10 ignores the NMI output
// RULE_13: Bit 9 ignores disk data port I/O
// RULE_14: Bit 8 ignores coprocessor I/O cycles
// RULE_15: Bits 7-6 exclude the attention interrupt line
// RULE_16: Bits 5-3 exclude requests of lines 8,7,0
// RULE_17: Bits 2-0 exclude in-service of lines 8,7,0
// RULE_18: Enable bit idles or starts the monitor
// RULE_19: Timeout sets flag, attention, restarts counting
// RULE_20: Timeout is coarse 64 s plus fine 7.8 ms
// RULE_21: Activity latch sets always, cleared writing zero
// RULE_22: Each source reduced to a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
`include "aqs_cfg.svh"
module aqs_activity_qualifier
    import aqs_pkg::*;
#(
    parameter int FINE_TICK_CYCLES = `AQS_FINE_STEP_NS / `AQS_CLK_PERIOD_NS,
    parameter int COARSE_TICKS     = int'((64'(`AQS_COARSE_STEP_S) * 64'(`AQS_NS_PER_S)) / 64'(`AQS_FINE_STEP_NS))
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] ioAddr,
    input  wire logic        ioWrite,
    input  wire logic        ioRead,
    input  wire logic [15:0] ioWrData,
    output logic      [15:0] ioRdData,
    output logic             ioRdValid,
    input  wire logic [15:0] pendingRequestBits,
    input  wire logic [15:0] inServiceBits,
    input  wire logic [15:0] irqCtrlMask,
    input  wire logic [7:2]  powerInputs,
    input  wire logic        nmiOut,
    input  wire logic        dmaCycle,
    input  wire logic        sxProcessor,
    input  wire logic        memIoSelect,
    input  wire logic        addrA23,
    input  wire logic        chipSelectHit,
    input  wire logic        diskPortHit,
    input  wire logic        diskChipSelEnable,
    output logic             localAttention,
    output logic             activityPulse
);
    localparam logic [`AQS_PRESC_W-1:0] PRESC_LAST = `AQS_PRESC_W'(FINE_TICK_CYCLES - 1);

    function automatic logic [3:0] attnLine(input logic [1:0] sel);
        logic [3:0] line;
        line = `AQS_ATTN_LINE_0;
        unique case (sel)
            2'h0: line = `AQS_ATTN_LINE_0;
            2'h1: line = `AQS_ATTN_LINE_1;
            2'h2: line = `AQS_ATTN_LINE_2;
            2'h3: line = `AQS_ATTN_LINE_3;
        endcase
        return line;
    endfunction

    // Total timeout in fine steps; the sum fits the 17-bit counter
    function automatic logic [`AQS_TIMER_W-1:0] timeoutTarget(input logic [7:0] s);
        logic [`AQS_PRESC_W-1:0] t;
        t = `AQS_PRESC_W'(s[7:4]) * `AQS_PRESC_W'(COARSE_TICKS) + `AQS_PRESC_W'(s[3:0]); // [RULE_20]
        return t[`AQS_TIMER_W-1:0];
    endfunction

    // Power input pins cross into the clock domain
    logic [5:0] pmcMeta_q;
    logic [5:0] pmcSync_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pmcMeta_q <= 6'h00;
            pmcSync_q <= 6'h00;
        end else begin
            pmcMeta_q <= powerInputs;
            pmcSync_q <= pmcMeta_q;
        end
    end

    // Register state
    aqs_word_t           mask_q;
    aqs_word_t           mask_d;
    logic                reqEn_q;
    logic                reqEn_d;
    logic [7:0]          setting_q;
    logic [7:0]          setting_d;
    logic                latch_q;
    logic                latch_d;
    logic                inactivity_detected_q;
    logic                inactivity_detected_d;
    logic                after_q;
    logic                after_d;
    logic                before_q;
    logic                before_d;
    aqs_state_t          state_q;
    aqs_state_t          state_d;
    logic [`AQS_PRESC_W-1:0] presc_q;
    logic [`AQS_PRESC_W-1:0] presc_d;
    logic [`AQS_TIMER_W-1:0] tick_q;
    logic [`AQS_TIMER_W-1:0] tick_d;
    aqs_word_t           rdData_q;
    aqs_word_t           rdData_d;
    logic                rdValid_q;
    logic                rdValid_d;
    logic                actOut_q;
    logic                actOut_d;

    // Source qualification
    logic                  ioCycle;
    logic [15:0]           reqEnables;
    logic [15:0]           svcEnables;
    logic [15:0]           reqQual;
    logic [15:0]           svcQual;
    logic [5:0]            pmcQual;
    logic                  nmiQual;
    logic                  copQual;
    logic                  diskQual;
    logic                  pcsQual;
    logic [`AQS_SRC_W-1:0] srcLevel;
    logic [`AQS_SRC_W-1:0] srcPulse;
    logic                  actPulse;
    logic [2:0]            pmcSel;

    assign ioCycle = ioRead | ioWrite;
    assign pmcSel  = mask_q[`AQS_MASK_SEL_HI:`AQS_MASK_SEL_LO];

    always_comb begin
        reqEnables = 16'hffff;
        svcEnables = 16'hffff;
        reqEnables[`AQS_IRQ_CASCADE] = 1'b0; // [RULE_04]
        svcEnables[`AQS_IRQ_CASCADE] = 1'b0; // [RULE_04]
        reqEnables[attnLine(mask_q[`AQS_MASK_ATTN_HI:`AQS_MASK_ATTN_LO])] = 1'b0; // [RULE_15]
        svcEnables[attnLine(mask_q[`AQS_MASK_ATTN_HI:`AQS_MASK_ATTN_LO])] = 1'b0; // [RULE_15]
        if (mask_q[`AQS_MASK_RTC_REQ]) begin
            reqEnables[`AQS_IRQ_RTC] = 1'b0; // [RULE_16]
        end
        if (mask_q[`AQS_MASK_PAR_REQ]) begin
            reqEnables[`AQS_IRQ_PARALLEL] = 1'b0; // [RULE_16]
        end
        if (mask_q[`AQS_MASK_TICK_REQ]) begin
            reqEnables[`AQS_IRQ_TICK] = 1'b0; // [RULE_16]
        end
        if (mask_q[`AQS_MASK_RTC_SVC]) begin
            svcEnables[`AQS_IRQ_RTC] = 1'b0; // [RULE_17]
        end
        if (mask_q[`AQS_MASK_PAR_SVC]) begin
            svcEnables[`AQS_IRQ_PARALLEL] = 1'b0; // [RULE_17]
        end
        if (mask_q[`AQS_MASK_TICK_SVC]) begin
            svcEnables[`AQS_IRQ_TICK] = 1'b0; // [RULE_17]
        end
        // The interrupt controller's own mask hides these two requests
        reqEnables[`AQS_IRQ_GATED_A] = reqEnables[`AQS_IRQ_GATED_A] & ~irqCtrlMask[`AQS_IRQ_GATED_A]; // [RULE_05]
        reqEnables[`AQS_IRQ_GATED_B] = reqEnables[`AQS_IRQ_GATED_B] & ~irqCtrlMask[`AQS_IRQ_GATED_B]; // [RULE_05]
    end

    always_comb begin
        reqQual = reqEn_q ? (pendingRequestBits & reqEnables) : 16'h0000; // [RULE_06]
        svcQual = inServiceBits & svcEnables; // [RULE_17]
        pmcQual = 6'h00;
        // Codes 6 and 7 watch nothing
        if (pmcSel < `AQS_SEL_FIRST_OFF) begin
            pmcQual[pmcSel] = ~(pmcSync_q[pmcSel] ^ mask_q[`AQS_MASK_POL]); // [RULE_09] [RULE_10]
        end
        nmiQual  = nmiOut & ~mask_q[`AQS_MASK_NMI]; // [RULE_12]
        copQual  = ~mask_q[`AQS_MASK_COP] & (sxProcessor ? (ioCycle & addrA23 & ~memIoSelect) :
                   (ioCycle & (ioAddr >= `AQS_COP_FIRST) & (ioAddr <= `AQS_COP_LAST))); // [RULE_14]
        diskQual = ioCycle & diskPortHit & diskChipSelEnable & ~mask_q[`AQS_MASK_DISK]; // [RULE_13]
        pcsQual  = ioCycle & chipSelectHit & ~mask_q[`AQS_MASK_PCS]; // [RULE_08]
        srcLevel = {reqQual, svcQual, pmcQual, nmiQual, dmaCycle, copQual, diskQual, pcsQual}; // [RULE_03]
    end

    aqs_edge_pulse u_edge (
        .clk      (clk),
        .reset_n  (reset_n),
        .srcLevel (srcLevel),
        .srcPulse (srcPulse)
    );

    assign actPulse = |srcPulse; // [RULE_22]

    // Port decode, timer and flags
    logic wrMask;
    logic wrCtrl;
    logic counting;
    logic tickStrobe;
    logic timeoutHit;
    logic flagClear;
    logic [`AQS_TIMER_W-1:0] target;

    assign wrMask     = ioWrite & (ioAddr == `AQS_MASK_ADDR);
    assign wrCtrl     = ioWrite & (ioAddr == `AQS_CTRL_ADDR);
    assign counting   = (state_q == AQS_COUNT);
    assign target     = timeoutTarget(setting_q);
    assign tickStrobe = counting & (presc_q == PRESC_LAST);
    // A zero setting never times out; the monitor then only watches
    assign timeoutHit = tickStrobe & ~actPulse & (target != '0) &
                        ((tick_q + `AQS_TIMER_W'(1)) == target); // [RULE_01]
    assign flagClear  = wrCtrl & (~ioWrData[`AQS_CTRL_INACTIVITY_DETECTED] | ~ioWrData[`AQS_CTRL_ENABLE]);

    always_comb begin
        mask_d    = wrMask ? ioWrData : mask_q; // [RULE_07]
        reqEn_d   = wrCtrl ? ioWrData[`AQS_CTRL_REQ_EN] : reqEn_q;
        // Setting is only meant to change while idle; it is stored regardless
        setting_d = wrCtrl ? ioWrData[7:0] : setting_q;
        state_d   = state_q;
        presc_d   = presc_q;
        tick_d    = tick_q;
        unique case (state_q)
            AQS_IDLE: begin
                presc_d = '0;
                tick_d  = '0;
                if (wrCtrl && ioWrData[`AQS_CTRL_ENABLE]) begin
                    state_d = AQS_COUNT; // [RULE_18]
                end
            end
            AQS_COUNT: begin
                if (wrCtrl && !ioWrData[`AQS_CTRL_ENABLE]) begin
                    state_d = AQS_IDLE; // [RULE_18]
                    presc_d = '0;
                    tick_d  = '0;
                end else if (actPulse) begin
                    presc_d = '0; // [RULE_02]
                    tick_d  = '0; // [RULE_02]
                end else if (tickStrobe) begin
                    presc_d = '0;
                    tick_d  = timeoutHit ? '0 : tick_q + `AQS_TIMER_W'(1); // [RULE_19]
                end else begin
                    presc_d = presc_q + `AQS_PRESC_W'(1);
                end
            end
            default: begin
                state_d = AQS_IDLE;
                presc_d = '0;
                tick_d  = '0;
            end
        endcase
        // Every flag below lets a hardware set win over a clear in the same cycle
        latch_d  = (latch_q & ~(wrCtrl & ~ioWrData[`AQS_CTRL_LATCH])) | actPulse; // [RULE_21]
        inactivity_detected_d  = (inactivity_detected_q & ~flagClear) | timeoutHit; // [RULE_19]
        after_d  = (after_q & ~flagClear) | (counting & actPulse & inactivity_detected_q);
        before_d = (before_q & ~flagClear) | (counting & actPulse & ~inactivity_detected_q);
        actOut_d = actPulse;
        rdValid_d = ioRead & ((ioAddr == `AQS_MASK_ADDR) | (ioAddr == `AQS_CTRL_ADDR));
        rdData_d  = 16'h0000;
        if (ioRead && ioAddr == `AQS_MASK_ADDR) begin
            rdData_d = mask_q; // [RULE_07]
        end else if (ioRead && ioAddr == `AQS_CTRL_ADDR) begin
            rdData_d = {reqEn_q, 2'b00, latch_q, inactivity_detected_q, after_q, before_q, counting, setting_q};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask_q    <= `AQS_MASK_RESET;
            reqEn_q   <= 1'b0;
            setting_q <= `AQS_SETTING_RESET;
            latch_q   <= 1'b0;
            inactivity_detected_q   <= 1'b0;
            after_q   <= 1'b0;
            before_q  <= 1'b0;
            state_q   <= AQS_IDLE;
            presc_q   <= '0;
            tick_q    <= '0;
            rdData_q  <= 16'h0000;
            rdValid_q <= 1'b0;
            actOut_q  <= 1'b0;
        end else begin
            mask_q    <= mask_d;
            reqEn_q   <= reqEn_d;
            setting_q <= setting_d;
            latch_q   <= latch_d;
            inactivity_detected_q   <= inactivity_detected_d;
            after_q   <= after_d;
            before_q  <= before_d;
            state_q   <= state_d;
            presc_q   <= presc_d;
            tick_q    <= tick_d;
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
            actOut_q  <= actOut_d;
        end
    end

    assign ioRdData       = rdData_q;
    assign ioRdValid      = rdValid_q;
    assign localAttention = inactivity_detected_q; // [RULE_01]
    assign activityPulse  = actOut_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    mask_write_a: assert property (wrMask |=> mask_q == $past(ioWrData)) // [RULE_07]
        else $error("mask register did not take the written word");
    attn_rise_cause_a: assert property ($rose(localAttention) |-> $past(timeoutHit) && tick_q == '0) // [RULE_19]
        else $error("attention rose without a timeout");
    activity_restart_a: assert property (counting && actPulse && !wrCtrl |=> tick_q == '0 && presc_q == '0) // [RULE_02]
        else $error("activity did not restart the timeout count");
    cascade_ignored_a: assert property (!srcLevel[`AQS_IRQ_CASCADE + 11] && !srcLevel[`AQS_IRQ_CASCADE + 27]
        && !reqQual[`AQS_IRQ_CASCADE] && !svcQual[`AQS_IRQ_CASCADE]) // [RULE_04]
        else $error("cascade line seen as activity");
    request_master_a: assert property (!reqEn_q |-> reqQual == 16'h0000) // [RULE_06]
        else $error("request counted without master enable");
    latch_sets_a: assert property (actPulse |=> latch_q [*2] or (latch_q ##1 !latch_q)) // [RULE_21]
        else $error("activity latch missed an event");
    idle_clears_a: assert property (wrCtrl && !ioWrData[`AQS_CTRL_ENABLE] && !timeoutHit
        |=> !inactivity_detected_q && !counting && tick_q == '0) // [RULE_18]
        else $error("disable did not idle the monitor");
    pmc_disabled_a: assert property (pmcSel >= `AQS_SEL_FIRST_OFF |-> pmcQual == 6'h00) // [RULE_10]
        else $error("power input watched while disabled");
    pulse_single_a: assert property ((srcPulse & $past(srcPulse)) == '0) // [RULE_22]
        else $error("source pulse lasted more than one cycle");
    attn_line_a: assert property (!reqQual[attnLine(mask_q[7:6])] && !svcQual[attnLine(mask_q[7:6])]) // [RULE_15]
        else $error("attention line seen as activity");
    nmi_masked_a: assert property (mask_q[`AQS_MASK_NMI] |-> !nmiQual) // [RULE_12]
        else $error("masked NMI seen as activity");
    gated_req_a: assert property (irqCtrlMask[`AQS_IRQ_GATED_A] |-> !reqQual[`AQS_IRQ_GATED_A]) // [RULE_05]
        else $error("controller-masked request seen as activity");

    timeout_c: cover property (counting ##1 timeoutHit ##1 localAttention);
    activity_count_c: cover property (counting && actPulse && before_q == 1'b0 ##1 before_q);
    after_inactivity_detected_c: cover property (inactivity_detected_q && actPulse ##1 after_q);
    restart_c: cover property (timeoutHit ##1 counting [*3]);
endmodule
`default_nettype wire

//--- aqs_source_model.sv
// Interrupt controller and I/O cycle decoder model that raises one activity source on request.
`timescale 1ns/1ns
`default_nettype none
module aqs_source_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [2:0]  kind,
    input  wire logic [3:0]  bitSel,
    input  wire logic        pol,
    input  wire logic        sx,
    output logic      [15:0] pendingRequestBits,
    output logic      [15:0] inServiceBits,
    output logic      [7:2]  powerInputs,
    output logic             nmiOut,
    output logic             dmaCycle,
    output logic             cycRead,
    output logic      [15:0] cycAddr,
    output logic             memIoSelect,
    output logic             addrA23,
    output logic             chipSelectHit,
    output logic             diskPortHit
);
    int         cnt = 0;
    logic [2:0] k   = 3'h0;
    logic [3:0] b   = 4'h0;
    logic       lvl;
    logic       cyc;
    logic [7:0] pm;
    // Levels stand six cycles; an I/O access is one cycle, a decoder hit exists only then
    always @(posedge clk) begin
        if (go) begin
            cnt <= 6;
            k   <= kind;
            b   <= bitSel;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign lvl                = cnt > 0;
    assign cyc                = cnt == 6 && k >= 3'h5;
    assign pm                 = 8'h01 << b;
    assign pendingRequestBits = (lvl && k == 3'h0) ? 16'h0001 << b : 16'h0000;
    assign inServiceBits      = (lvl && k == 3'h1) ? 16'h0001 << b : 16'h0000;
    // Edge and level latch enables of the watched pin are left clear by software
    assign powerInputs        = {6{~pol}} ^ ((lvl && k == 3'h2) ? pm[7:2] : 6'h00);
    assign nmiOut             = lvl && k == 3'h3;
    assign dmaCycle           = lvl && k == 3'h4;
    assign cycRead            = cyc;
    assign cycAddr            = (k == 3'h7 && !sx) ? 16'h00f8 + 16'(b) : 16'h0300;
    assign memIoSelect        = !cyc;
    assign addrA23            = cyc && k == 3'h7 && sx;
    assign chipSelectHit      = cyc && k == 3'h5;
    assign diskPortHit        = cyc && k == 3'h6;
endmodule
`default_nettype wire

//--- test_aqs_activity_qualifier.sv
// Self-checking bench for the activity source qualifier.
`timescale 1ns/1ns
`default_nettype none
`include "aqs_cfg.svh"
module test_aqs_activity_qualifier;
    import aqs_pkg::*;
    localparam int FINE   = 4;
    localparam int COARSE = 3;
    localparam logic [15:0] C = `AQS_CTRL_ADDR;
    logic        clk = 1'b0, reset_n = 1'b0, tbRead = 1'b0, ioWrite = 1'b0, go = 1'b0, pol = 1'b0;
    logic        sxProcessor = 1'b0, diskChipSelEnable = 1'b0;
    logic [15:0] tbAddr = 16'h0000, ioWrData = 16'h0000, irqCtrlMask = 16'h0000;
    logic [2:0]  kind = 3'h0;
    logic [3:0]  bitSel = 4'h0;
    logic [15:0] ioAddr, ioRdData, pendingRequestBits, inServiceBits, cycAddr;
    logic [7:2]  powerInputs;
    logic        ioRead, ioRdValid, nmiOut, dmaCycle, cycRead, memIoSelect, addrA23;
    logic        chipSelectHit, diskPortHit, localAttention, activityPulse;
    int          failCount = 0, comparisons = 0, n;
    logic [3:0]  att [4] = '{4'h5, 4'ha, 4'hb, 4'hf};
    logic [3:0]  line [3] = '{4'h8, 4'h7, 4'h0};

    always #2 clk = ~clk;
    assign ioRead = tbRead | cycRead;
    assign ioAddr = cycRead ? cycAddr : tbAddr;

    aqs_activity_qualifier #(.FINE_TICK_CYCLES(FINE), .COARSE_TICKS(COARSE)) u_aqs_activity_qualifier (
        .clk(clk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
        .pendingRequestBits(pendingRequestBits), .inServiceBits(inServiceBits), .irqCtrlMask(irqCtrlMask),
        .powerInputs(powerInputs), .nmiOut(nmiOut), .dmaCycle(dmaCycle), .sxProcessor(sxProcessor),
        .memIoSelect(memIoSelect), .addrA23(addrA23), .chipSelectHit(chipSelectHit),
        .diskPortHit(diskPortHit), .diskChipSelEnable(diskChipSelEnable),
        .localAttention(localAttention), .activityPulse(activityPulse));

    aqs_source_model u_aqs_source_model (
        .clk(clk), .go(go), .kind(kind), .bitSel(bitSel), .pol(pol), .sx(sxProcessor),
        .pendingRequestBits(pendingRequestBits), .inServiceBits(inServiceBits), .powerInputs(powerInputs),
        .nmiOut(nmiOut), .dmaCycle(dmaCycle), .cycRead(cycRead), .cycAddr(cycAddr),
        .memIoSelect(memIoSelect), .addrA23(addrA23), .chipSelectHit(chipSelectHit),
        .diskPortHit(diskPortHit));

    task automatic printVerdict();
        $display("Totals: %0d comparisons, %0d mismatches", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkCount(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            failCount++;
            $display("BAD t=%0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic endTest(input string name);
        $display("%s finished: %0d comparisons, %0d mismatches", name, comparisons, failCount);
    endtask

    task automatic ioWr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        tbAddr   <= a;
        ioWrData <= d;
        ioWrite  <= 1'b1;
        @(posedge clk);
        ioWrite  <= 1'b0;
    endtask

    // The answer stands one cycle only, so it is looked at right after the edge that follows the read
    task automatic ioRd(input logic [15:0] a, input logic [15:0] care, input logic [15:0] exp, input logic vld);
        @(posedge clk);
        tbAddr <= a;
        tbRead <= 1'b1;
        @(posedge clk);
        tbRead <= 1'b0;
        #1;
        checkWord({15'h0000, ioRdValid}, {15'h0000, vld});
        if (vld) begin
            checkWord(ioRdData & care, exp);
        end
    endtask

    task automatic waitAttn(input int lim, output int cnt);
        cnt = 0;
        while (localAttention !== 1'b1) begin
            @(posedge clk);
            #1 cnt++;
            if (cnt > lim) begin
                failCount++;
                $display("BAD t=%0t local attention never came", $time);
                printVerdict();
            end
        end
    endtask

    // One source event, a six-cycle level or a one-cycle I/O access, must give exactly expN pulses
    task automatic trial(input logic [2:0] k, input logic [3:0] b, input logic [15:0] m,
                         input logic [15:0] c, input logic p, input int expN);
        int cnt;
        cnt = 0;
        pol <= p;
        ioWr(`AQS_MASK_ADDR, m);
        ioWr(C, c);
        repeat (5) @(posedge clk);
        kind   <= k;
        bitSel <= b;
        go     <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1 cnt += int'(activityPulse === 1'b1);
        end
        checkCount(cnt, expN);
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        ioRd(`AQS_MASK_ADDR, 16'hffff, `AQS_MASK_RESET, 1'b1);
        ioRd(C, 16'hffff, 16'h0000, 1'b1);
        ioWr(`AQS_MASK_ADDR, 16'h5a3c);
        ioRd(`AQS_MASK_ADDR, 16'hffff, 16'h5a3c, 1'b1);
        ioRd(16'hd873, 16'hffff, 16'h0000, 1'b0);
        endTest("registers");
        @(posedge clk);
        diskChipSelEnable <= 1'b1;
        trial(3'h3, 4'h0, 16'h3800, 16'h0000, 1'b0, 1);
        trial(3'h3, 4'h0, 16'h3c00, 16'h0000, 1'b0, 0);
        trial(3'h4, 4'h0, 16'hffff, 16'h0000, 1'b0, 1);
        trial(3'h5, 4'h0, 16'h3800, 16'h0000, 1'b0, 1);
        trial(3'h5, 4'h0, 16'hb800, 16'h0000, 1'b0, 0);
        trial(3'h6, 4'h0, 16'h3800, 16'h0000, 1'b0, 1);
        trial(3'h6, 4'h0, 16'h3a00, 16'h0000, 1'b0, 0);
        trial(3'h7, 4'h7, 16'h3800, 16'h0000, 1'b0, 1);
        trial(3'h7, 4'h8, 16'h3800, 16'h0000, 1'b0, 0);
        trial(3'h7, 4'h7, 16'h3900, 16'h0000, 1'b0, 0);
        diskChipSelEnable <= 1'b0;
        sxProcessor       <= 1'b1;
        trial(3'h6, 4'h0, 16'h3800, 16'h0000, 1'b0, 0);
        trial(3'h7, 4'h0, 16'h3800, 16'h0000, 1'b0, 1);
        trial(3'h7, 4'h0, 16'h3900, 16'h0000, 1'b0, 0);
        sxProcessor <= 1'b0;
        trial(3'h0, 4'h8, 16'h3800, 16'h0000, 1'b0, 0);
        for (int i = 0; i < 3; i++) begin
            trial(3'h0, line[i], 16'h3800, 16'h8000, 1'b0, 1);
            trial(3'h0, line[i], 16'h3800 | (16'h0020 >> i), 16'h8000, 1'b0, 0);
            trial(3'h1, line[i], 16'h3800, 16'h0000, 1'b0, 1);
            trial(3'h1, line[i], 16'h3800 | (16'h0004 >> i), 16'h0000, 1'b0, 0);
        end
        trial(3'h0, 4'h2, 16'h3800, 16'h8000, 1'b0, 0);
        trial(3'h1, 4'h2, 16'h3800, 16'h0000, 1'b0, 0);
        irqCtrlMask <= 16'h0018;
        trial(3'h0, 4'h3, 16'h3800, 16'h8000, 1'b0, 0);
        trial(3'h0, 4'h4, 16'h3800, 16'h8000, 1'b0, 0);
        irqCtrlMask <= 16'h0000;
        trial(3'h0, 4'h4, 16'h3800, 16'h8000, 1'b0, 1);
        for (int i = 0; i < 4; i++) begin
            trial(3'h0, att[i], 16'h3800 | 16'(i << 6), 16'h8000, 1'b0, 0);
            trial(3'h1, att[i], 16'h3800 | 16'(i << 6), 16'h0000, 1'b0, 0);
            trial(3'h1, att[i], 16'h3800 | 16'(((i + 1) % 4) << 6), 16'h0000, 1'b0, 1);
        end
        for (int s = 0; s < 8; s++) begin
            trial(3'h2, (s < 6) ? 4'(s + 2) : 4'h2, 16'h4000 | 16'(s << 11), 16'h0000, 1'b1, int'(s < 6));
        end
        trial(3'h2, 4'h4, 16'h1000, 16'h0000, 1'b0, 1);
        endTest("sources");
        ioRd(C, 16'h1000, 16'h1000, 1'b1);
        ioWr(C, 16'h1000);
        ioRd(C, 16'h1000, 16'h1000, 1'b1);
        ioWr(C, 16'h0000);
        ioRd(C, 16'h1000, 16'h0000, 1'b1);
        ioWr(C, 16'h0101);
        waitAttn(40, n);
        checkCount(n, FINE);
        ioWr(C, 16'h0000);
        @(posedge clk);
        #1 checkWord({15'h0000, localAttention}, 16'h0000);
        ioWr(C, 16'h0111);
        waitAttn(60, n);
        checkCount(n, (COARSE + 1) * FINE);
        ioRd(C, 16'h0fff, 16'h0911, 1'b1);
        // Clearing the flag alone keeps the monitor counting from the timeout edge
        ioWr(C, 16'h0111);
        @(posedge clk);
        #1 checkWord({15'h0000, localAttention}, 16'h0000);
        waitAttn(60, n);
        checkCount(int'(n < 17), 1);
        ioWr(C, 16'h0000);
        ioWr(C, 16'h0102);
        repeat (5) @(posedge clk);
        kind <= 3'h3;
        go   <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        waitAttn(40, n);
        checkCount(int'(n >= 2 * FINE && n <= 2 * FINE + 3), 1);
        for (int j = 0; j < 2; j++) begin
            ioWr(C, (j == 0) ? 16'h0100 : 16'h0001);
            n = 0;
            repeat (30) begin
                @(posedge clk);
                #1 n += int'(localAttention === 1'b1);
            end
            checkCount(n, 0);
        end
        endTest("timeout");
        printVerdict();
    end
endmodule
`default_nettype wire
